/* core/pnpe_defines.vh */
// Register offsets, field positions, reset values and timing constants of the port status bank
`ifndef PNPE_DEFINES_VH
`define PNPE_DEFINES_VH
// Register byte offsets
`define PNPE_OFF_NEXT_PAGE_RX 8'hea
`define PNPE_OFF_EEE_ADV 8'hec
`define PNPE_OFF_WAKE_ERR 8'hee
`define PNPE_ADDR_NEXT_PAGE_RX 12'h00ea
`define PNPE_ADDR_EEE_ADV 12'h00ec
`define PNPE_ADDR_WAKE_ERR 12'h00ee
// Next page field positions
`define PNPE_NP_MORE_BIT 15
`define PNPE_NP_MSG_BIT 13
`define PNPE_NP_SECOND_ACKNOWLEDGE_BIT 12
`define PNPE_NP_TOGGLE_BIT 11
`define PNPE_NP_CODE_HI 10
`define PNPE_NP_CODE_LO 0
// Advertisement field positions
`define PNPE_ADV_LP_HI 14
`define PNPE_ADV_LP_LO 9
`define PNPE_ADV_LOC_HI 6
`define PNPE_ADV_LOC_LO 2
`define PNPE_ADV_TX100_BIT 1
// Reset values
`define PNPE_NP_RST 16'h0000
`define PNPE_TX100_RST 1'b1
`define PNPE_WAKE_ERR_RST 16'h0000
// Wake time limit in nanoseconds and the matching cycle count at 8 ns
`define PNPE_WAKE_LIMIT_NS 20500
`define PNPE_CLK_PERIOD_NS 8
`define PNPE_WAKE_LIMIT_CYC (`PNPE_WAKE_LIMIT_NS / `PNPE_CLK_PERIOD_NS)
`endif

/* core/pnpe_wake_err_counter.v */
// Saturating clear-on-read counter of EEE wake errors
`timescale 1ns/100ps
`include "pnpe_defines.vh"
module pnpe_wake_err_counter #(
  parameter WIDTH = 16
) (
  input wire clock,
  input wire srst,
  input wire wakeDone,
  input wire clearRead,
  output wire [WIDTH-1:0] count
);

  reg wakeDonePrev_ff;
  reg [WIDTH-1:0] count_ff;
  reg [WIDTH-1:0] nxt_count;
  wire rise;
  wire atMax;

  // ****************************************
  // Rising edge of the timer-done condition
  // ****************************************
  assign rise = wakeDone & ~wakeDonePrev_ff;
  assign atMax = &count_ff;

  // Clear first, then add; a coincident event leaves one behind
  always @* begin
    nxt_count = count_ff;
    if (clearRead) begin
      nxt_count = {WIDTH{1'b0}};
    end
    if (rise && (clearRead || !atMax)) begin
      nxt_count = nxt_count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Counter state
  always @(posedge clock) begin
    if (srst) begin
      wakeDonePrev_ff <= 1'b0;
      count_ff <= `PNPE_WAKE_ERR_RST;
    end else begin
      wakeDonePrev_ff <= wakeDone;
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;
endmodule

/* core/pnpe_status_regs.v */
// Next page, EEE advertisement and wake error registers of one PHY port
`timescale 1ns/100ps
// Constants are needed by the parameter defaults, so they come in before the module
`include "pnpe_defines.vh"
// How it works
// - Bit 12 of the received next page register shows the partner's second acknowledge, reset 0.
// - The first next page toggle is the inverse of bit 11 of the base code word.
// - Bits 10 to 0 of the received next page register hold the partner code field, reset 0.
// - Advertisement bits 14 to 9 show the partner's EEE support per mode, reset 0.
// - Advertisement bits 6 to 2 show local EEE support per mode from localEeeAbility and are read-only.
// - Advertisement bit 1 is a writable local 100BASE-TX EEE flag reset to 1; reserved bits read 0.
// - The wake error counter adds one on each false-to-true change of the wake timer done.
// - The wake timer is done when a wake-up from low power idle lasts over 20.5 us.
// - The wake error counter holds at all ones instead of wrapping.
// - Reading the wake error counter returns its value and then clears it; it resets to 0.
// - Bit 13 of the received next page register shows message page (1) or unformatted (0).
// - Bit 15 of the received next page register shows that more pages follow.
module pnpe_status_regs #(
  parameter WAKE_LIMIT_CYC = `PNPE_WAKE_LIMIT_CYC
) (
  input wire clock,
  input wire srst,
  input wire [11:0] regAddr,
  input wire regRead,
  input wire regWrite,
  input wire [15:0] regWrData,
  output reg [15:0] regRdData,
  input wire pageRxValid,
  input wire [15:0] pageRxWord,
  input wire baseToggle,
  input wire firstPage,
  input wire [5:0] partnerEeeAbility,
  input wire [4:0] localEeeAbility,
  input wire wakeActive,
  output wire toggleError,
  output wire localTx100Eee
);

  // ****************************************
  // Registers
  // ****************************************
  reg [15:0] nextPage_ff;
  reg expToggle_ff;
  reg tx100_ff;
  reg [5:0] partnerAdv_ff;
  reg [14:0] wakeTimer_ff;
  reg wakeDone_ff;
  reg toggleErr_ff;
  wire [15:0] wakeCount;
  wire wakeClear;
  wire expectedToggle;

  // Expected toggle: first page inverts the base word, later pages alternate
  assign expectedToggle = firstPage ? ~baseToggle : expToggle_ff;

  // Capture of a received next page; a page with a stale toggle is dropped
  always @(posedge clock) begin
    if (srst) begin
      nextPage_ff <= `PNPE_NP_RST;
      expToggle_ff <= 1'b0;
      toggleErr_ff <= 1'b0;
    end else begin
      toggleErr_ff <= 1'b0;
      if (pageRxValid) begin
        if (pageRxWord[`PNPE_NP_TOGGLE_BIT] == expectedToggle) begin
          nextPage_ff <= pageRxWord;
          expToggle_ff <= ~pageRxWord[`PNPE_NP_TOGGLE_BIT];
        end else begin
          toggleErr_ff <= 1'b1;
        end
      end
    end
  end

  assign toggleError = toggleErr_ff;

  // Advertisement state: partner bits follow negotiation, bit 1 written by host
  always @(posedge clock) begin
    if (srst) begin
      tx100_ff <= `PNPE_TX100_RST;
      partnerAdv_ff <= 6'h00;
    end else begin
      partnerAdv_ff <= partnerEeeAbility;
      if (regWrite && regAddr == `PNPE_ADDR_EEE_ADV) begin
        tx100_ff <= regWrData[`PNPE_ADV_TX100_BIT];
      end
    end
  end

  // Only advertisement; disabling EEE is done elsewhere in the PCS control
  assign localTx100Eee = tx100_ff;

  // ****************************************
  // Wake timer
  // ****************************************
  // Counts wake-up time; done stays high until the wake ends
  always @(posedge clock) begin
    if (srst) begin
      wakeTimer_ff <= 15'h0000;
      wakeDone_ff <= 1'b0;
    end else if (!wakeActive) begin
      wakeTimer_ff <= 15'h0000;
      wakeDone_ff <= 1'b0;
    end else if (wakeTimer_ff >= WAKE_LIMIT_CYC[14:0]) begin
      wakeDone_ff <= 1'b1;
    end else begin
      wakeTimer_ff <= wakeTimer_ff + 15'h0001;
    end
  end

  assign wakeClear = regRead && (regAddr == `PNPE_ADDR_WAKE_ERR);

  pnpe_wake_err_counter #(
    .WIDTH(16)
  ) uWakeErr (
    .clock(clock),
    .srst(srst),
    .wakeDone(wakeDone_ff),
    .clearRead(wakeClear),
    .count(wakeCount)
  );

  // ****************************************
  // Read data
  // ****************************************
  // Registered read; returns the pre-clear count
  always @(posedge clock) begin
    if (srst) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      if (regAddr == `PNPE_ADDR_NEXT_PAGE_RX) begin
        regRdData <= nextPage_ff;
      end else if (regAddr == `PNPE_ADDR_EEE_ADV) begin
        regRdData <= {1'b0, partnerAdv_ff, 2'b00, localEeeAbility, tx100_ff, 1'b0};
      end else if (regAddr == `PNPE_ADDR_WAKE_ERR) begin
        regRdData <= wakeCount;
      end else begin
        regRdData <= 16'h0000;
      end
    end
  end
endmodule

/* testbench/pnpe_partner_model.sv */
// Link partner model presenting received next pages
`timescale 1ns/100ps
module pnpe_partner_model (
  input wire clock,
  input wire sendPage,
  input wire breakToggle,
  input wire [15:0] pageIn,
  input wire first,
  input wire baseToggle,
  output reg pageRxValid = 1'b0,
  output reg firstPage = 1'b0,
  output reg [15:0] pageRxWord = 16'h0000
);
  reg togFf = 1'b0;
  wire nxtTog = first ? ~baseToggle : ~togFf;
  // ****
  // Page driver
  // ****
  // Idle word flips each cycle so no stale page looks valid
  always @(posedge clock) begin
    pageRxValid <= sendPage;
    firstPage <= first;
    pageRxWord <= sendPage ? {pageIn[15:12], nxtTog ^ breakToggle, pageIn[10:0]} : ~pageRxWord;
    if (sendPage && !breakToggle) begin
      togFf <= nxtTog; // Broken page keeps sync state
    end
  end
endmodule

/* testbench/pnpe_chk_sva.sv */
// Port checks of the port status register bank
`timescale 1ns/100ps
module pnpe_chk #(parameter WAKE_LIMIT_CYC = 2562) (
  input wire clock,
  input wire srst,
  input wire [11:0] regAddr,
  input wire regRead,
  input wire regWrite,
  input wire [15:0] regWrData,
  input wire [15:0] regRdData,
  input wire pageRxValid,
  input wire [15:0] pageRxWord,
  input wire baseToggle,
  input wire firstPage,
  input wire [4:0] localEeeAbility,
  input wire wakeActive,
  input wire toggleError,
  input wire localTx100Eee
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire rdA = regRead && regAddr == 12'h00ec;
  wire rdW = regRead && regAddr == 12'h00ee;
  wire wrA = regWrite && regAddr == 12'h00ec;
  wire tgF = pageRxValid && firstPage;
  AST_ADV: assert property (rdA |=> regRdData[15] == 1'b0 && regRdData[8:7] == 2'b00 &&
    regRdData[6:0] == {$past(localEeeAbility), $past(localTx100Eee), 1'b0}) else $error("adv");
  AST_WEC_CLR: assert property ((!wakeActive)[*4] ##0 rdW ##2 rdW |=>
    regRdData == 16'h0000) else $error("wake count not cleared");
  AST_TX100: assert property (wrA |=> localTx100Eee == $past(regWrData[1])) else $error("wr");
  AST_TX100_HOLD: assert property (!wrA |=> $stable(localTx100Eee)) else $error("tx100");
  AST_TOG_BAD: assert property (tgF && pageRxWord[11] == baseToggle |=> toggleError)
    else $error("bad toggle kept");
  AST_TOG_OK: assert property (tgF && pageRxWord[11] != baseToggle |=> !toggleError)
    else $error("good toggle refused");
  AST_NO_ERR: assert property (!pageRxValid |=> !toggleError) else $error("stray err");
  AST_UNMAP: assert property (regRead && regAddr == 12'h00e8 |=> regRdData == 16'h0000)
    else $error("unmapped");
  cover property (tgF && toggleError);
  cover property (rdW ##1 regRdData == 16'h0001);
  cover property (wrA);
endmodule
bind pnpe_status_regs pnpe_chk #(.WAKE_LIMIT_CYC(WAKE_LIMIT_CYC)) pnpe_chk_inst(.*);

/* testbench/pnpe_tb.sv */
// Self-checking bench of the port status register bank
`timescale 1ns/100ps
module tb;
  reg clock = 1'b0, srst = 1'b1, regRead = 1'b0, regWrite = 1'b0, sendPage = 1'b0;
  reg breakToggle = 1'b0, first = 1'b0, baseToggle = 1'b0, wakeActive = 1'b0;
  reg [11:0] regAddr = 12'h000;
  reg [15:0] regWrData = 16'h0000, pageIn = 16'h0000;
  reg [5:0] partnerEeeAbility = 6'h00;
  reg [4:0] localEeeAbility = 5'h00;
  wire [15:0] regRdData, pageRxWord;
  wire pageRxValid, firstPage, toggleError, localTx100Eee;
  integer err_count = 0, cmp_count = 0;
  always #4 clock = ~clock;
  pnpe_status_regs #(.WAKE_LIMIT_CYC(10)) pnpe_status_regs_inst(.*);
  pnpe_partner_model pnpe_partner_model_inst(.*);
  // ****
  // Access tasks
  // ****
  task chk(input [15:0] s, input [15:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task rd(input [11:0] a, input [15:0] e);
    @(posedge clock) regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock) regRead <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  task wr(input [11:0] a, input [15:0] d);
    @(posedge clock) regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock) regWrite <= 1'b0;
  endtask
  task pg(input b, input f, input [15:0] d);
    @(posedge clock) sendPage <= 1'b1;
    breakToggle <= b;
    first <= f;
    pageIn <= d;
    @(posedge clock) sendPage <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task wake(input integer n);
    @(posedge clock) wakeActive <= 1'b1;
    repeat (n) @(posedge clock);
    wakeActive <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task results;
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard at 500 cycles, about five times the roughly 95 cycles needed
  initial begin
    #4000;
    err_count = err_count + 1;
    results;
  end
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    rd(12'h00ea, 16'h0000);
    rd(12'h00ec, 16'h0002);
    rd(12'h00ee, 16'h0000);
    rd(12'h00e8, 16'h0000);
    wr(12'h00ec, 16'h0000);
    rd(12'h00ec, 16'h0000);
    chk({15'h0000, localTx100Eee}, 16'h0000);
    wr(12'h00ec, 16'hffff);
    rd(12'h00ec, 16'h0002);
    @(posedge clock) partnerEeeAbility <= 6'h2a;
    localEeeAbility <= 5'h15;
    @(posedge clock);
    rd(12'h00ec, 16'h5456);
    pg(1'b1, 1'b1, 16'hffff);
    rd(12'h00ea, 16'h0000);
    @(posedge clock) baseToggle <= 1'b1;
    pg(1'b0, 1'b1, 16'ha5a5);
    rd(12'h00ea, 16'ha5a5);
    pg(1'b0, 1'b0, 16'h1234);
    rd(12'h00ea, 16'h1a34);
    pg(1'b1, 1'b0, 16'hffff);
    rd(12'h00ea, 16'h1a34);
    wake(20);
    wake(5);
    rd(12'h00ee, 16'h0001);
    rd(12'h00ee, 16'h0000);
    results;
  end
endmodule
